/* shared/mitc_pkg.sv */
package mitc_pkg;

  // Instruction cycle framing
  localparam int CYCLE_PHASES = 4;
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CYCLE_PHASES - 1);

  // Program word and counter widths
  localparam int PROG_W = 16;
  localparam int PC_W = 11;
  localparam int OP_W = 5;

  // Data space map
  localparam logic [7:0] PC_LOW_BYTE_ADDR = 8'h00;
  localparam logic [7:0] TBL_PTR_ADDR = 8'h01;
  localparam logic [7:0] TBL_HIGH_ADDR = 8'h02;
  localparam logic [7:0] PORT_ADDR = 8'h03;
  localparam logic [7:0] RAM_BASE = 8'h10;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [PROG_W-1:0] NOP_WORD = 16'h0000;

  // Opcodes, word[15:11]
  localparam logic [OP_W-1:0] OP_NOP = 5'h00;
  localparam logic [OP_W-1:0] OP_TRANSFER_A_M = 5'h01;
  localparam logic [OP_W-1:0] OP_TRANSFER_M_A = 5'h02;
  localparam logic [OP_W-1:0] OP_TRANSFER_A_X = 5'h03;
  localparam logic [OP_W-1:0] OP_ADD_A_M = 5'h04;
  localparam logic [OP_W-1:0] OP_ADD_A_X = 5'h05;
  localparam logic [OP_W-1:0] OP_SUB_A_M = 5'h06;
  localparam logic [OP_W-1:0] OP_SUB_A_X = 5'h07;
  localparam logic [OP_W-1:0] OP_AND_A_M = 5'h08;
  localparam logic [OP_W-1:0] OP_OR_A_M = 5'h09;
  localparam logic [OP_W-1:0] OP_XOR_A_M = 5'h0a;
  localparam logic [OP_W-1:0] OP_AND_A_X = 5'h0b;
  localparam logic [OP_W-1:0] OP_XOR_A_X = 5'h0c;
  localparam logic [OP_W-1:0] OP_INVERT_M = 5'h0d;
  localparam logic [OP_W-1:0] OP_INVERT_INTO_A = 5'h0e;
  localparam logic [OP_W-1:0] OP_ADD_ONE_M = 5'h0f;
  localparam logic [OP_W-1:0] OP_ADD_ONE_TO_ACC = 5'h10;
  localparam logic [OP_W-1:0] OP_SUBTRACT_ONE = 5'h11;
  localparam logic [OP_W-1:0] OP_SUBTRACT_ONE_INTO_ACC = 5'h12;
  localparam logic [OP_W-1:0] OP_ROTATE_RIGHT = 5'h13;
  localparam logic [OP_W-1:0] OP_ROTATE_LEFT = 5'h14;
  localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_VIA_CARRY = 5'h15;
  localparam logic [OP_W-1:0] OP_ROTATE_LEFT_VIA_CARRY = 5'h16;
  localparam logic [OP_W-1:0] OP_BIT_SET = 5'h17;
  localparam logic [OP_W-1:0] OP_BIT_CLEAR = 5'h18;
  localparam logic [OP_W-1:0] OP_SKIP_IF_ZERO = 5'h19;
  localparam logic [OP_W-1:0] OP_SKIP_IF_BIT_ZERO = 5'h1a;
  localparam logic [OP_W-1:0] OP_JUMP = 5'h1b;
  localparam logic [OP_W-1:0] OP_CALL = 5'h1c;
  localparam logic [OP_W-1:0] OP_SUBROUTINE_EXIT = 5'h1d;
  localparam logic [OP_W-1:0] OP_INTERRUPT_EXIT = 5'h1e;
  localparam logic [OP_W-1:0] OP_TABLE_READ = 5'h1f;

  typedef enum logic {MITC_CYC_EXEC, MITC_CYC_TABLE} mitc_cyc_t;

endpackage

/* rtl/mitc_core.sv */
`timescale 1ns/1ps
module mitc_core
  import mitc_pkg::*;
#(
  parameter int RAM_DEPTH = 16,
  parameter int STACK_DEPTH = 4,
  parameter logic [2:0] TABLE_PAGE = 3'h7
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [PROG_W-1:0] prog_data_in,
  input wire logic [7:0] port_in,
  output logic [PC_W-1:0] prog_addr_out,
  output logic [7:0] port_out,
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic zero_out
);

  localparam int RIW = $clog2(RAM_DEPTH);
  localparam int SPW = $clog2(STACK_DEPTH);

  if (RAM_DEPTH < 2 || (1 << RIW) != RAM_DEPTH || int'(RAM_BASE) + RAM_DEPTH > 256)
  begin : g_bad_ram
    $error("RAM_DEPTH must be a power of two that fits the data space");
  end
  if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH)
  begin : g_bad_stack
    $error("STACK_DEPTH must be a power of two of at least two");
  end

  function automatic logic ram_hit(input logic [7:0] a);
    return int'(a) >= int'(RAM_BASE) && int'(a) < int'(RAM_BASE) + RAM_DEPTH;
  endfunction

  function automatic logic [RIW-1:0] ram_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - RAM_BASE;
    return d[RIW-1:0];
  endfunction

  logic [PHASE_W-1:0] phase_r;
  mitc_cyc_t cyc_r;
  logic [PROG_W-1:0] ir_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] prog_addr_r;
  logic [7:0] acc_r;
  logic carry_r;
  logic zero_r;
  logic [7:0] tbl_ptr_r;
  logic [7:0] tbl_high_r;
  logic [7:0] tbl_dest_r;
  logic [7:0] port_out_r;
  logic [7:0] port_s1_r;
  logic [7:0] port_s2_r;
  logic [7:0] port_s3_r;
  logic [7:0] port_val_r;
  logic [7:0] ram_r [RAM_DEPTH];
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [SPW-1:0] sp_r;

  logic [OP_W-1:0] op;
  logic [2:0] bsel;
  logic [7:0] fld;
  logic [PC_W-1:0] tgt;
  logic end_cyc;
  logic exec_now;
  logic table_end;
  logic [7:0] rd;
  logic [7:0] opnd;
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [7:0] res;
  logic c_nxt;
  logic z_upd;
  logic c_upd;
  logic acc_we;
  logic mem_we;
  logic skip;
  logic branch;
  logic push;
  logic pop;
  logic tbl_go;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic pcl_hit;
  logic redirect;
  logic [PC_W-1:0] redir_addr;
  logic [PC_W-1:0] pc_inc;
  logic [SPW-1:0] sp_dec;

  assign op = ir_r[15:11];
  assign bsel = ir_r[10:8];
  assign fld = ir_r[7:0];
  assign tgt = ir_r[PC_W-1:0];
  assign end_cyc = phase_r == PHASE_LAST;
  assign exec_now = end_cyc && cyc_r == MITC_CYC_EXEC;
  assign table_end = end_cyc && cyc_r == MITC_CYC_TABLE;
  assign pc_inc = pc_r + PC_W'(1);
  assign sp_dec = sp_r - SPW'(1);
  assign opnd = (op == OP_ADD_A_X || op == OP_SUB_A_X || op == OP_AND_A_X ||
                 op == OP_XOR_A_X) ? fld : rd;
  assign sum9 = {1'b0, acc_r} + {1'b0, opnd};
  assign diff9 = {1'b0, acc_r} - {1'b0, opnd};

  // Data space read
  always_comb
  begin
    if (fld == PC_LOW_BYTE_ADDR)
      rd = pc_r[7:0];
    else if (fld == TBL_PTR_ADDR)
      rd = tbl_ptr_r;
    else if (fld == TBL_HIGH_ADDR)
      rd = tbl_high_r;
    else if (fld == PORT_ADDR)
      rd = port_val_r;
    else if (ram_hit(fld))
      rd = ram_r[ram_index(fld)];
    else
      rd = BYTE_RST;
  end

  // Instruction decode and arithmetic
  always_comb
  begin
    res = BYTE_RST;
    c_nxt = carry_r;
    c_upd = 1'b0;
    z_upd = 1'b0;
    acc_we = 1'b0;
    mem_we = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tbl_go = 1'b0;
    case (op)
      OP_TRANSFER_A_M, OP_TRANSFER_A_X:
      begin
        res = op == OP_TRANSFER_A_M ? rd : fld;
        acc_we = 1'b1;
      end
      OP_TRANSFER_M_A:
      begin
        res = acc_r;
        mem_we = 1'b1;
      end
      OP_ADD_A_M, OP_ADD_A_X:
      begin
        res = sum9[7:0];
        c_nxt = sum9[8];
        {c_upd, z_upd, acc_we} = 3'h7;
      end
      OP_SUB_A_M, OP_SUB_A_X:
      begin
        res = diff9[7:0];
        c_nxt = diff9[8];
        {c_upd, z_upd, acc_we} = 3'h7;
      end
      OP_AND_A_M, OP_AND_A_X:
      begin
        res = acc_r & opnd;
        {z_upd, acc_we} = 2'h3;
      end
      OP_OR_A_M:
      begin
        res = acc_r | opnd;
        {z_upd, acc_we} = 2'h3;
      end
      OP_XOR_A_M, OP_XOR_A_X:
      begin
        res = acc_r ^ opnd;
        {z_upd, acc_we} = 2'h3;
      end
      OP_INVERT_M, OP_INVERT_INTO_A:
      begin
        res = ~rd;
        z_upd = 1'b1;
        acc_we = op == OP_INVERT_INTO_A;
        mem_we = op == OP_INVERT_M;
      end
      OP_ADD_ONE_M, OP_ADD_ONE_TO_ACC:
      begin
        res = rd + 8'h01;
        z_upd = 1'b1;
        acc_we = op == OP_ADD_ONE_TO_ACC;
        mem_we = op == OP_ADD_ONE_M;
      end
      OP_SUBTRACT_ONE, OP_SUBTRACT_ONE_INTO_ACC:
      begin
        res = rd - 8'h01;
        z_upd = 1'b1;
        acc_we = op == OP_SUBTRACT_ONE_INTO_ACC;
        mem_we = op == OP_SUBTRACT_ONE;
      end
      OP_ROTATE_RIGHT:
      begin
        res = {rd[0], rd[7:1]};
        mem_we = 1'b1;
      end
      OP_ROTATE_LEFT:
      begin
        res = {rd[6:0], rd[7]};
        mem_we = 1'b1;
      end
      OP_ROTATE_RIGHT_VIA_CARRY:
      begin
        res = {carry_r, rd[7:1]};
        c_nxt = rd[0];
        {c_upd, mem_we} = 2'h3;
      end
      OP_ROTATE_LEFT_VIA_CARRY:
      begin
        res = {rd[6:0], carry_r};
        c_nxt = rd[7];
        {c_upd, mem_we} = 2'h3;
      end
      OP_BIT_SET:
      begin
        res = rd | (8'h01 << bsel);
        mem_we = 1'b1;
      end
      OP_BIT_CLEAR:
      begin
        res = rd & ~(8'h01 << bsel);
        mem_we = 1'b1;
      end
      OP_SKIP_IF_ZERO:
        skip = rd == BYTE_RST;
      OP_SKIP_IF_BIT_ZERO:
        skip = ~rd[bsel];
      OP_JUMP:
        branch = 1'b1;
      OP_CALL:
        {branch, push} = 2'h3;
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT:
        pop = 1'b1;
      OP_TABLE_READ:
        tbl_go = 1'b1;
      default:
        res = BYTE_RST;
    endcase
  end

  // Data space write and program counter redirection
  always_comb
  begin
    wr_en = (exec_now && mem_we) || table_end;
    wr_addr = table_end ? tbl_dest_r : fld;
    wr_data = table_end ? prog_data_in[7:0] : res;
    pcl_hit = wr_en && wr_addr == PC_LOW_BYTE_ADDR;
    redirect = (exec_now && (branch || pop)) || pcl_hit;
    if (exec_now && branch)
      redir_addr = tgt;
    else if (exec_now && pop)
      redir_addr = stack_r[sp_dec];
    else
      redir_addr = {pc_r[PC_W-1:8], wr_data};
  end

  // Phase counter
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      phase_r <= PHASE_FIRST;
    else
      phase_r <= end_cyc ? PHASE_FIRST : phase_r + PHASE_W'(1);
  end

  // Fetch sequencer
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cyc_r <= MITC_CYC_EXEC;
      ir_r <= NOP_WORD;
      pc_r <= PC_RST;
      prog_addr_r <= PC_RST;
      tbl_dest_r <= BYTE_RST;
    end
    else if (end_cyc)
    begin
      case (cyc_r)
        MITC_CYC_EXEC:
        begin
          if (redirect)
          begin
            ir_r <= NOP_WORD;
            pc_r <= redir_addr;
            prog_addr_r <= redir_addr;
          end
          else if (skip)
          begin
            ir_r <= NOP_WORD;
            pc_r <= pc_inc;
            prog_addr_r <= pc_inc;
          end
          else if (tbl_go)
          begin
            ir_r <= prog_data_in;
            pc_r <= pc_inc;
            prog_addr_r <= {TABLE_PAGE, tbl_ptr_r};
            tbl_dest_r <= fld;
            cyc_r <= MITC_CYC_TABLE;
          end
          else
          begin
            ir_r <= prog_data_in;
            pc_r <= pc_inc;
            prog_addr_r <= pc_inc;
          end
        end
        MITC_CYC_TABLE:
        begin
          cyc_r <= MITC_CYC_EXEC;
          if (redirect)
          begin
            ir_r <= NOP_WORD;
            pc_r <= redir_addr;
            prog_addr_r <= redir_addr;
          end
          else
            prog_addr_r <= pc_r;
        end
        default:
          cyc_r <= MITC_CYC_EXEC;
      endcase
    end
  end

  // Return stack
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sp_r <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_r[i] <= PC_RST;
    end
    else if (exec_now && push)
    begin
      stack_r[sp_r] <= pc_r;
      sp_r <= sp_r + SPW'(1);
    end
    else if (exec_now && pop)
      sp_r <= sp_dec;
  end

  // Accumulator and flags
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      acc_r <= BYTE_RST;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
    end
    else if (exec_now)
    begin
      if (acc_we)
        acc_r <= res;
      if (c_upd)
        carry_r <= c_nxt;
      if (z_upd)
        zero_r <= res == BYTE_RST;
    end
  end

  // Data memory and special bytes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tbl_ptr_r <= BYTE_RST;
      tbl_high_r <= BYTE_RST;
      port_out_r <= BYTE_RST;
      for (int i = 0; i < RAM_DEPTH; i++)
        ram_r[i] <= BYTE_RST;
    end
    else
    begin
      if (table_end)
        tbl_high_r <= prog_data_in[15:8];
      if (wr_en && wr_addr == TBL_PTR_ADDR)
        tbl_ptr_r <= wr_data;
      if (wr_en && wr_addr == PORT_ADDR)
        port_out_r <= wr_data;
      if (wr_en && ram_hit(wr_addr))
        ram_r[ram_index(wr_addr)] <= wr_data;
    end
  end

  // Port input synchroniser
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      port_s1_r <= BYTE_RST;
      port_s2_r <= BYTE_RST;
      port_s3_r <= BYTE_RST;
      port_val_r <= BYTE_RST;
    end
    else
    begin
      port_s1_r <= port_in;
      port_s2_r <= port_s1_r;
      port_s3_r <= port_s2_r;
      port_val_r <= (~(port_s2_r ^ port_s3_r) & port_s2_r) |
                    ((port_s2_r ^ port_s3_r) & port_val_r);
    end
  end

  assign prog_addr_out = prog_addr_r;
  assign port_out = port_out_r;
  assign acc_out = acc_r;
  assign carry_out = carry_r;
  assign zero_out = zero_r;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  phase_walk_a: assert property (
    rst_n_in && phase_r == 2'h0 |=> phase_r == 2'h1 ##1 phase_r == 2'h2 ##1 phase_r == 2'h3
    ##1 phase_r == 2'h0) else $error("instruction cycle is not four clocks");
  jump_flush_a: assert property (
    exec_now && op == OP_JUMP |=> (ir_r == NOP_WORD && pc_r == $past(tgt))
    ##1 (ir_r == NOP_WORD && $stable(pc_r)) [*3])
    else $error("jump did not discard prefetch");
  pcl_jump_a: assert property (
    exec_now && pcl_hit |=> ir_r == NOP_WORD && pc_r[7:0] == $past(wr_data))
    else $error("low byte write did not redirect");
  skip_taken_a: assert property (
    exec_now && skip && !redirect |=> ir_r == NOP_WORD && pc_r == $past(pc_inc))
    else $error("taken skip mishandled");
  skip_not_a: assert property (
    exec_now && (op == OP_SKIP_IF_ZERO) && rd != 8'h00 |=> ir_r == $past(prog_data_in))
    else $error("untaken skip lost next instruction");
  add_carry_a: assert property (
    exec_now && op == OP_ADD_A_M |=> carry_r == $past(sum9[8]) && acc_r == $past(sum9[7:0]))
    else $error("add carry wrong");
  logic_zero_a: assert property (
    exec_now && (op == OP_AND_A_M || op == OP_XOR_A_X) |=> zero_r == (acc_r == 8'h00))
    else $error("zero flag wrong");
  inc_acc_a: assert property (
    exec_now && op == OP_ADD_ONE_TO_ACC |=> acc_r == $past(rd) + 8'h01)
    else $error("increment wrong");
  rot_carry_a: assert property (
    exec_now && op == OP_ROTATE_RIGHT_VIA_CARRY |=> carry_r == $past(rd[0]))
    else $error("rotate carry wrong");
  call_save_a: assert property (
    exec_now && op == OP_CALL |=> stack_r[$past(sp_r)] == $past(pc_r) && pc_r == $past(tgt))
    else $error("call did not save return address");
  table_load_a: assert property (
    exec_now && tbl_go && !redirect |=> cyc_r == MITC_CYC_TABLE ##4 cyc_r == MITC_CYC_EXEC
    && tbl_high_r == $past(prog_data_in[15:8])) else $error("table read failed");

endmodule // mitc_core

/* verif/test_mitc_core.sv */
`timescale 1ns/1ps
`define CHECK(nm, ex, sn) \
  begin \
    samples_checked++; \
    if ((sn) !== (ex)) \
    begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", nm, ex, sn); \
    end \
  end

module test_mitc_core
  import mitc_pkg::*;
;
  logic clk_in;
  logic rst_n_in;
  logic [PROG_W-1:0] prog_data_in;
  logic [7:0] port_in;
  logic [PC_W-1:0] prog_addr_out;
  logic [7:0] port_out;
  logic [7:0] acc_out;
  logic carry_out;
  logic zero_out;
  logic [PROG_W-1:0] rom [0:(1<<PC_W)-1];
  logic [PC_W-1:0] tr [0:63];
  logic [7:0] st_acc [0:63];
  logic [7:0] st_port [0:63];
  logic st_c [0:63];
  logic st_z [0:63];
  int wp;
  int mismatches;
  int samples_checked;
  localparam logic [2:0] TABLE_PAGE_TB = 3'h7;

  mitc_core dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .prog_data_in(prog_data_in),
    .port_in(port_in),
    .prog_addr_out(prog_addr_out),
    .port_out(port_out),
    .acc_out(acc_out),
    .carry_out(carry_out),
    .zero_out(zero_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Program memory, answers well before the fetch edge
  always @(posedge clk_in) prog_data_in <= rom[prog_addr_out];

  task automatic load_clear;
    for (int i = 0; i < (1 << PC_W); i++) rom[i] = NOP_WORD;
    wp = 0;
  endtask

  task automatic p(input logic [OP_W-1:0] op, input logic [2:0] b, input logic [7:0] d);
    rom[wp] = {op, b, d};
    wp++;
  endtask

  // Reset, then record address and state for n instruction cycles
  task automatic run(input int n);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int k = 0; k < n; k++)
    begin
      for (int ph = 1; ph <= 4; ph++)
      begin
        @(posedge clk_in);
        #1;
        if (ph == 1)
          tr[k] = prog_addr_out;
        else if (ph < 4)
          `CHECK("address stand", tr[k], prog_addr_out)
        else
        begin
          st_acc[k] = acc_out;
          st_port[k] = port_out;
          st_c[k] = carry_out;
          st_z[k] = zero_out;
        end
      end
    end
  endtask

  task automatic ck_trace(input int q[$]);
    foreach (q[i]) `CHECK("address trace", PC_W'(q[i]), tr[i])
  endtask

  task automatic cs(input int k, input logic [7:0] a);
    `CHECK("acc", a, st_acc[k])
  endtask

  // Call, return and jump with discarded prefetches
  task automatic t_branch(input logic [OP_W-1:0] exit_op);
    load_clear;
    p(OP_TRANSFER_A_X, 3'h0, 8'h01);
    p(OP_CALL, 3'h0, 8'h06);
    p(OP_ADD_A_X, 3'h0, 8'h10);
    p(OP_JUMP, 3'h0, 8'h03);
    p(OP_TRANSFER_A_X, 3'h0, 8'h55);
    wp = 6;
    p(OP_ADD_A_X, 3'h0, 8'h01);
    p(exit_op, 3'h0, 8'h00);
    p(OP_TRANSFER_A_X, 3'h0, 8'h77);
    run(12);
    ck_trace('{0, 1, 2, 6, 7, 8, 2, 3, 4, 3, 4, 3});
    cs(4, 8'h02);
    cs(11, 8'h12);
  endtask

  // Low byte write, skips, increment and decrement
  task automatic t_pcl_skip;
    load_clear;
    p(OP_TRANSFER_A_X, 3'h0, 8'h05);
    p(OP_TRANSFER_M_A, 3'h0, PC_LOW_BYTE_ADDR);
    p(OP_TRANSFER_A_X, 3'h0, 8'h99);
    wp = 5;
    p(OP_TRANSFER_M_A, 3'h0, RAM_BASE);
    p(OP_SUBTRACT_ONE, 3'h0, RAM_BASE);
    p(OP_SKIP_IF_ZERO, 3'h0, RAM_BASE);
    p(OP_ADD_ONE_TO_ACC, 3'h0, RAM_BASE);
    p(OP_SKIP_IF_BIT_ZERO, 3'h1, RAM_BASE);
    p(OP_TRANSFER_A_X, 3'h0, 8'hee);
    p(OP_SUBTRACT_ONE_INTO_ACC, 3'h0, RAM_BASE);
    p(OP_JUMP, 3'h0, 8'h0c);
    run(14);
    ck_trace('{0, 1, 2, 5, 6, 7, 8, 9, 10, 11, 12, 13, 12, 13});
    cs(3, 8'h05);
    `CHECK("zero", 1'b0, st_z[5])
    cs(7, 8'h05);
    cs(9, 8'h05);
    cs(10, 8'h03);
  endtask

  // Flags, logic, rotates, bit ops, transfers and table read
  task automatic t_datapath;
    load_clear;
    p(OP_TRANSFER_A_X, 3'h0, 8'hff);
    p(OP_ADD_A_X, 3'h0, 8'h01);
    p(OP_ADD_A_X, 3'h0, 8'h01);
    p(OP_SUB_A_X, 3'h0, 8'h02);
    p(OP_SUB_A_X, 3'h0, 8'h01);
    p(OP_AND_A_X, 3'h0, 8'h01);
    p(OP_XOR_A_X, 3'h0, 8'h5a);
    p(OP_TRANSFER_M_A, 3'h0, RAM_BASE);
    p(OP_XOR_A_M, 3'h0, RAM_BASE);
    p(OP_OR_A_M, 3'h0, RAM_BASE);
    p(OP_INVERT_INTO_A, 3'h0, RAM_BASE);
    p(OP_INVERT_M, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_ROTATE_RIGHT_VIA_CARRY, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_ROTATE_LEFT_VIA_CARRY, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_ROTATE_RIGHT, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_ROTATE_LEFT, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_ADD_ONE_M, 3'h0, RAM_BASE);
    p(OP_ADD_ONE_TO_ACC, 3'h0, RAM_BASE);
    p(OP_SUBTRACT_ONE, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_X, 3'h0, 8'h0f);
    p(OP_TRANSFER_M_A, 3'h0, 8'h11);
    p(OP_BIT_SET, 3'h7, 8'h11);
    p(OP_BIT_CLEAR, 3'h0, 8'h11);
    p(OP_TRANSFER_A_M, 3'h0, 8'h11);
    p(OP_TRANSFER_M_A, 3'h0, PORT_ADDR);
    p(OP_TRANSFER_A_X, 3'h0, 8'h20);
    p(OP_TRANSFER_M_A, 3'h0, TBL_PTR_ADDR);
    p(OP_TABLE_READ, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_M, 3'h0, TBL_HIGH_ADDR);
    p(OP_TRANSFER_A_M, 3'h0, PORT_ADDR);
    p(OP_JUMP, 3'h0, 8'h25);
    rom[{TABLE_PAGE_TB, 8'h20}] = 16'hc33c;
    run(39);
    cs(2, 8'h00);
    `CHECK("carry", 1'b1, st_c[2])
    `CHECK("zero", 1'b1, st_z[2])
    cs(3, 8'h01);
    `CHECK("carry", 1'b0, st_c[3])
    cs(4, 8'hff);
    `CHECK("carry", 1'b1, st_c[4])
    `CHECK("carry", 1'b0, st_c[5])
    `CHECK("zero", 1'b1, st_z[6])
    `CHECK("zero", 1'b0, st_z[7])
    `CHECK("zero", 1'b1, st_z[9])
    cs(10, 8'h5a);
    cs(11, 8'ha5);
    cs(13, 8'ha5);
    `CHECK("carry", 1'b1, st_c[14])
    cs(15, 8'h52);
    `CHECK("carry", 1'b0, st_c[16])
    cs(17, 8'ha5);
    cs(19, 8'hd2);
    cs(21, 8'ha5);
    cs(23, 8'ha7);
    cs(25, 8'ha5);
    cs(30, 8'h8e);
    `CHECK("port", 8'h8e, st_port[31])
    ck_trace('{0, 1, 2});
    `CHECK("table address", {TABLE_PAGE_TB, 8'h20}, tr[35])
    `CHECK("address", 11'h023, tr[36])
    cs(36, 8'h3c);
    cs(37, 8'hc3);
    cs(38, 8'h69);
  endtask

  // Memory add, subtract and AND, plus both skip outcomes
  task automatic t_mem_skip;
    load_clear;
    p(OP_TRANSFER_A_X, 3'h0, 8'hf0);
    p(OP_TRANSFER_M_A, 3'h0, RAM_BASE);
    p(OP_TRANSFER_A_X, 3'h0, 8'h20);
    p(OP_ADD_A_M, 3'h0, RAM_BASE);
    p(OP_SUB_A_M, 3'h0, RAM_BASE);
    p(OP_AND_A_M, 3'h0, RAM_BASE);
    p(OP_AND_A_M, 3'h0, 8'h11);
    p(OP_SKIP_IF_ZERO, 3'h0, 8'h11);
    p(OP_TRANSFER_A_X, 3'h0, 8'hee);
    p(OP_SKIP_IF_BIT_ZERO, 3'h4, RAM_BASE);
    p(OP_TRANSFER_A_X, 3'h0, 8'h5c);
    p(OP_JUMP, 3'h0, 8'h0b);
    run(12);
    ck_trace('{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11});
    cs(4, 8'h10);
    `CHECK("carry", 1'b1, st_c[4])
    cs(5, 8'h20);
    `CHECK("carry", 1'b1, st_c[5])
    `CHECK("zero", 1'b0, st_z[6])
    cs(7, 8'h00);
    `CHECK("zero", 1'b1, st_z[7])
    cs(10, 8'h00);
    cs(11, 8'h5c);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    port_in = 8'h69;
    mismatches = 0;
    samples_checked = 0;
    load_clear;
    t_branch(OP_SUBROUTINE_EXIT);
    t_branch(OP_INTERRUPT_EXIT);
    t_pcl_skip;
    t_mem_skip;
    t_datapath;
    final_report;
  end
endmodule // test_mitc_core
